// ---- design/pls_access_check.sv ----
// access permission and alias resolution for label register system accesses
// assumes: level and controls are stable for the access cycle
`default_nettype none
module pls_access_check (
  input wire pls_pkg::pls_level_e level,
  input wire pls_pkg::pls_reg_e regName,
  input wire pls_pkg::pls_ctrl_s ctrl,
  output logic allowed,
  output pls_pkg::pls_reg_e target
);
  import pls_pkg::*;

  logic atLeast2;
  logic atLeast1;

  assign atLeast2 = (level == PLS_EL2) || (level == PLS_EL3);
  assign atLeast1 = (level != PLS_EL0);

  always_comb begin
    target = regName;
    if (regName == PLS_REG_GUEST && ctrl.hostExtensionBit) begin
      target = PLS_REG_HYP;
    end else if (regName == PLS_REG_HOST_ALIAS) begin
      target = PLS_REG_GUEST;
    end
  end

  always_comb begin
    case (regName)
      PLS_REG_APP: begin
        if (ctrl.trapLowerA) allowed = (level == PLS_EL3);
        else if (ctrl.appRegTrap) allowed = atLeast2;
        else allowed = atLeast1;
      end
      PLS_REG_GUEST: begin
        if (ctrl.hostExtensionBit) begin
          // redirected name follows the hypervisor register's gate
          allowed = ctrl.trapLowerA ? (level == PLS_EL3) : atLeast2;
        end else if (ctrl.trapLowerA) allowed = (level == PLS_EL3);
        else if (ctrl.guestRegTrap) allowed = atLeast2;
        else allowed = atLeast1;
      end
      PLS_REG_HYP: allowed = ctrl.trapLowerA ? (level == PLS_EL3) : atLeast2;
      PLS_REG_MON: allowed = (level == PLS_EL3);
      PLS_REG_HOST_ALIAS: begin
        // only a host at level 2 or 3 with the extension set and trap-lower clear may use the alias
        allowed = ctrl.hostExtensionBit && !ctrl.trapLowerA && atLeast2;
      end
      default: allowed = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ---- design/pls_label_select.sv ----
// top of the partition label select block: label registers, selection, labelling
// assumes: requests are synchronous to clk; controls are plain ports, no register bus
`default_nettype none
// Function
// - feature id field reads 0x0 when absent, 0x1 for version 1.
// - every request carries partition id, monitor group and security label.
// - each label register holds data and instruction ids with monitor groups.
// - source by level; level 0 uses guest register when lock set.
// - mapping at level 0/1 per enables and lock; never at levels 2, 3.
// - instruction fetches use the instruction partition field.
// - instruction table walks use the instruction partition field too.
// - data accesses use the data partition field.
// - data table walks use the data partition field too.
// - monitor group comes from same register and side as partition id.
// - unprivileged loads and stores label like ordinary ones at that level.
// - nested-virtualization memory accesses use hypervisor data labels.
// - profiling buffer writes use owning level data labels and security.
// - application register access gated by trap-lower and its trap bit.
// - guest register access gated by trap-lower and its trap bit.
// - hypervisor register accessible from level 3, or 2 when not trapped.
// - monitor register accessible only from level 3.
// - with host extension, guest register name reaches hypervisor register.
// - with host extension, alias name reaches the real guest register.
// - security label is 0 in Secure state and 1 in Non-secure.
// - with no valid mapping entry, default physical partition id is used.
module pls_label_select (
  input wire logic clk,
  input wire logic reset,
  input wire logic featurePresent,
  input wire pls_pkg::pls_ctrl_s ctrl,
  input wire logic [15:0] defaultVirtId,
  input wire logic [8*16-1:0] physTable,
  input wire logic [7:0] validBits,
  input wire logic reqValid,
  input wire pls_pkg::pls_req_e reqKind,
  input wire pls_pkg::pls_level_e level,
  input wire logic secureState,
  input wire pls_pkg::pls_level_e ownerLevel,
  input wire logic ownerSecure,
  input wire logic sysValid,
  input wire logic sysWrite,
  input wire pls_pkg::pls_reg_e sysReg,
  input wire pls_pkg::pls_label_s sysWdata,
  output logic [63:0] featureIdReg,
  output logic outValid,
  output pls_pkg::pls_tag_s outTag,
  output logic sysDone,
  output logic sysFault,
  output pls_pkg::pls_label_s sysRdata
);
  import pls_pkg::*;

  // four label registers held in flip-flops, indexed by level
  pls_label_s labelRegs [4];
  logic accAllowed;
  pls_reg_e accTarget;
  pls_level_e effLevel;
  logic effSecure;
  logic dataSide;
  pls_label_s selReg;
  logic [1:0] selIdx;
  logic mapOn;
  logic [15:0] rawId;
  logic [15:0] mappedId;
  pls_tag_s next_outTag;

  function automatic logic [1:0] regIndex(input pls_reg_e r);
    case (r)
      PLS_REG_APP: regIndex = 2'h0;
      PLS_REG_GUEST: regIndex = 2'h1;
      PLS_REG_HYP: regIndex = 2'h2;
      PLS_REG_MON: regIndex = 2'h3;
      default: regIndex = 2'h1;
    endcase
  endfunction

  pls_access_check accessCheck (
    .level(level),
    .regName(sysReg),
    .ctrl(ctrl),
    .allowed(accAllowed),
    .target(accTarget)
  );

  // side and level per request kind; walks and unprivileged accesses simply
  // inherit the level and side of what they serve, so no extra state is needed
  always_comb begin
    effLevel = level;
    effSecure = secureState;
    dataSide = 1'b1;
    case (reqKind)
      PLS_REQ_IFETCH: dataSide = 1'b0;
      PLS_REQ_IWALK: dataSide = 1'b0;
      PLS_REQ_DATA: dataSide = 1'b1;
      PLS_REQ_DWALK: dataSide = 1'b1;
      PLS_REQ_UNPRIV: dataSide = 1'b1;
      PLS_REQ_NESTED: effLevel = PLS_EL2;
      PLS_REQ_PROFBUF: begin
        effLevel = ownerLevel;
        effSecure = ownerSecure;
      end
      default: dataSide = 1'b1;
    endcase
  end

  always_comb begin
    case (effLevel)
      PLS_EL0: begin
        selIdx = ctrl.guestAppLock ? 2'h1 : 2'h0;
        mapOn = ctrl.guestAppLock ? ctrl.level1MapEnable : ctrl.level0MapEnable;
      end
      PLS_EL1: begin
        selIdx = 2'h1;
        mapOn = ctrl.level1MapEnable;
      end
      PLS_EL2: begin
        selIdx = 2'h2;
        mapOn = 1'b0;
      end
      PLS_EL3: begin
        selIdx = 2'h3;
        mapOn = 1'b0;
      end
      default: begin
        selIdx = 2'h3;
        mapOn = 1'b0;
      end
    endcase
  end

  assign selReg = labelRegs[selIdx];
  assign rawId = dataSide ? selReg.dataPartitionField : selReg.instrPartitionField;

  pls_vpm_map vpmMap (
    .virtId(rawId),
    .defaultVirtId(defaultVirtId),
    .physTable(physTable),
    .validBits(validBits),
    .physId(mappedId)
  );

  always_comb begin
    next_outTag.partitionId = mapOn ? mappedId : rawId;
    next_outTag.monitorGroup = dataSide ? selReg.dataMonitorGroupField
                                        : selReg.instrMonitorGroupField;
    next_outTag.securitySpaceLabel = effSecure ? PLS_SEC_LABEL_SECURE
                                               : PLS_SEC_LABEL_NONSEC;
  end

  // labels register alongside the request so they leave with it, one cycle on
  always_ff @(posedge clk) begin
    if (reset) begin
      outValid <= 1'b0;
      outTag <= '0;
    end else begin
      outValid <= reqValid;
      if (reqValid) outTag <= next_outTag;
    end
  end

  // system register writes through the resolved target
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) labelRegs[i] <= '0;
    end else if (sysValid && sysWrite && accAllowed) begin
      labelRegs[regIndex(accTarget)] <= sysWdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sysDone <= 1'b0;
      sysFault <= 1'b0;
      sysRdata <= '0;
    end else begin
      sysDone <= sysValid;
      sysFault <= sysValid && !accAllowed;
      if (sysValid && !sysWrite) begin
        sysRdata <= accAllowed ? labelRegs[regIndex(accTarget)] : '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      featureIdReg <= '0;
    end else begin
      featureIdReg <= '0;
      featureIdReg[PLS_FEAT_MSB:PLS_FEAT_LSB] <= featurePresent ? PLS_FEAT_V1
                                                                : PLS_FEAT_ABSENT;
    end
  end
endmodule
`default_nettype wire

// ---- design/pls_pkg.sv ----
// package for the partition label select block: field widths, encodings, carriers
// assumes: a single 20 MHz core clock and a synchronous active-high reset
`default_nettype none
package pls_pkg;
  localparam int PLS_PARTITION_ID_W = 16;
  localparam int PLS_PMG_W = 8;
  localparam int PLS_FEAT_LSB = 40;
  localparam int PLS_FEAT_MSB = 43;
  localparam logic [3:0] PLS_FEAT_ABSENT = 4'h0;
  localparam logic [3:0] PLS_FEAT_V1 = 4'h1;
  localparam logic PLS_SEC_LABEL_SECURE = 1'h0;
  localparam logic PLS_SEC_LABEL_NONSEC = 1'h1;
  localparam logic [15:0] PLS_DEFAULT_PARTITION_ID = 16'h0000;
  localparam logic [1:0] PLS_LBL_RESET = 2'h0;
  localparam int PLS_VPM_ENTRIES = 8;
  localparam int PLS_VPM_IDX_W = 3;

  // exception levels
  typedef enum logic [1:0] {
    PLS_EL0 = 2'h0,
    PLS_EL1 = 2'h1,
    PLS_EL2 = 2'h2,
    PLS_EL3 = 2'h3
  } pls_level_e;

  // request source kinds
  typedef enum logic [2:0] {
    PLS_REQ_IFETCH = 3'h0,
    PLS_REQ_IWALK = 3'h1,
    PLS_REQ_DATA = 3'h2,
    PLS_REQ_DWALK = 3'h3,
    PLS_REQ_UNPRIV = 3'h4,
    PLS_REQ_NESTED = 3'h5,
    PLS_REQ_PROFBUF = 3'h6
  } pls_req_e;

  // label register identities, also used for system register access names
  typedef enum logic [2:0] {
    PLS_REG_APP = 3'h0,
    PLS_REG_GUEST = 3'h1,
    PLS_REG_HYP = 3'h2,
    PLS_REG_MON = 3'h3,
    PLS_REG_HOST_ALIAS = 3'h4
  } pls_reg_e;

  typedef struct packed {
    logic [15:0] dataPartitionField;
    logic [15:0] instrPartitionField;
    logic [7:0] dataMonitorGroupField;
    logic [7:0] instrMonitorGroupField;
  } pls_label_s;

  typedef struct packed {
    logic [15:0] partitionId;
    logic [7:0] monitorGroup;
    logic securitySpaceLabel;
  } pls_tag_s;

  typedef struct packed {
    logic guestAppLock;
    logic level0MapEnable;
    logic level1MapEnable;
    logic appRegTrap;
    logic guestRegTrap;
    logic trapLowerA;
    logic hostExtensionBit;
  } pls_ctrl_s;
endpackage
`default_nettype wire

// ---- design/pls_vpm_map.sv ----
// virtual-to-physical partition mapping table lookup
// assumes: table contents come from registers kept outside this block
`default_nettype none
module pls_vpm_map (
  input wire logic [15:0] virtId,
  input wire logic [15:0] defaultVirtId,
  input wire logic [8*16-1:0] physTable,
  input wire logic [7:0] validBits,
  output logic [15:0] physId
);
  import pls_pkg::*;

  logic [2:0] idx;
  logic [2:0] defIdx;

  // out-of-range ids fold into the table by their low bits
  assign idx = virtId[2:0];
  assign defIdx = defaultVirtId[2:0];

  always_comb begin
    if (validBits[idx]) begin
      physId = physTable[idx*16 +: 16];
    end else if (validBits[defIdx]) begin
      physId = physTable[defIdx*16 +: 16];
    end else begin
      physId = PLS_DEFAULT_PARTITION_ID;
    end
  end
endmodule
`default_nettype wire

// ---- verif/pls_label_select_chk.sv ----
// checker for the partition label select block, bound to its top
// assumes: one clock, synchronous active-high reset
`default_nettype none
module pls_label_select_chk
  import pls_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic featurePresent,
  input wire pls_pkg::pls_ctrl_s ctrl,
  input wire logic reqValid,
  input wire pls_pkg::pls_req_e reqKind,
  input wire pls_pkg::pls_level_e level,
  input wire logic secureState,
  input wire logic ownerSecure,
  input wire logic sysValid,
  input wire pls_pkg::pls_reg_e sysReg,
  input wire logic [63:0] featureIdReg,
  input wire logic outValid,
  input wire pls_pkg::pls_tag_s outTag,
  input wire logic sysDone,
  input wire logic sysFault
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_answer_next: assert property (reqValid |=> outValid)
    else $error("request got no answer");
  a_no_extra: assert property (!reqValid |=> !outValid && $stable(outTag))
    else $error("tag moved without request");
  // back-to-back accesses are legal, so done is checked per edge, not as a fixed pulse
  a_done_next: assert property (sysValid |=> sysDone)
    else $error("access done missing");
  a_done_drop: assert property (!sysValid |=> !sysDone)
    else $error("access done without access");
  a_feature_on: assert property (featurePresent |=> featureIdReg == 64'h0000010000000000)
    else $error("feature field wrong");
  a_feature_off: assert property (!featurePresent |=> featureIdReg == 64'h0)
    else $error("feature field not zero");
  a_sec_label: assert property (reqValid && reqKind != PLS_REQ_PROFBUF
    |=> outTag.securitySpaceLabel == !$past(secureState)) else $error("space label wrong");
  a_prof_space: assert property (reqValid && reqKind == PLS_REQ_PROFBUF
    |=> outTag.securitySpaceLabel == !$past(ownerSecure)) else $error("owner space wrong");
  a_mon_only: assert property (sysValid && sysReg == PLS_REG_MON && level != PLS_EL3
    |=> sysFault) else $error("monitor reg reached");
  a_trap_lower: assert property (sysValid && ctrl.trapLowerA && level != PLS_EL3
    |=> sysFault) else $error("trap lower ignored");
  a_top_allowed: assert property (sysValid && level == PLS_EL3
    && sysReg != PLS_REG_HOST_ALIAS |=> !sysFault) else $error("top level refused");
  c_prof: cover property (reqValid && reqKind == PLS_REQ_PROFBUF);
  c_fault: cover property (sysFault);
  c_burst: cover property (reqValid [*3]);
endmodule
bind pls_label_select pls_label_select_chk u_chk (.clk(clk), .reset(reset),
  .featurePresent(featurePresent), .ctrl(ctrl), .reqValid(reqValid), .reqKind(reqKind),
  .level(level), .secureState(secureState), .ownerSecure(ownerSecure), .sysValid(sysValid),
  .sysReg(sysReg), .featureIdReg(featureIdReg), .outValid(outValid), .outTag(outTag),
  .sysDone(sysDone), .sysFault(sysFault));
`default_nettype wire

// ---- verif/pls_mem_sink.sv ----
// memory-side model that takes labelled requests
// assumes: a request stands for the one cycle its valid is high
`default_nettype none
module pls_mem_sink (
  input wire logic clk,
  input wire logic reset,
  input wire logic reqValid,
  input wire pls_pkg::pls_tag_s tag,
  output logic [15:0] accepted
);
  timeunit 1ns;
  timeprecision 100ps;
  // the interconnect never stalls, so each request whose partition id is not all x is counted at once
  always_ff @(posedge clk) begin
    if (reset) begin
      accepted <= 16'h0;
    end else if (reqValid && tag.partitionId !== 16'hxxxx) begin
      accepted <= accepted + 16'h1;
    end
  end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the partition label select block
// assumes: design and checker compiled first
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pls_pkg::*;
  typedef struct packed {
    pls_req_e kind;
    pls_level_e lvl;
    logic [2:0] ctl;
    logic sec;
    pls_tag_s exp;
  } pls_row_s;
  // ctl is {lock, level0 map, level1 map}; owner of the profiling buffer is secure level 2
  pls_row_s rw [10] = '{
    '{PLS_REQ_IFETCH, PLS_EL0, 3'h0, 1'b0, '{16'h010e, 8'h12, 1'b1}},
    '{PLS_REQ_DATA, PLS_EL0, 3'h4, 1'b0, '{16'h020d, 8'h21, 1'b1}},
    '{PLS_REQ_IWALK, PLS_EL1, 3'h2, 1'b0, '{16'h020e, 8'h22, 1'b1}},
    '{PLS_REQ_DWALK, PLS_EL2, 3'h3, 1'b0, '{16'h030d, 8'h31, 1'b1}},
    '{PLS_REQ_UNPRIV, PLS_EL1, 3'h0, 1'b1, '{16'h020d, 8'h21, 1'b0}},
    '{PLS_REQ_NESTED, PLS_EL1, 3'h0, 1'b0, '{16'h030d, 8'h31, 1'b1}},
    '{PLS_REQ_PROFBUF, PLS_EL0, 3'h0, 1'b0, '{16'h030d, 8'h31, 1'b0}},
    '{PLS_REQ_DATA, PLS_EL0, 3'h2, 1'b0, '{16'hc005, 8'h11, 1'b1}},
    '{PLS_REQ_IFETCH, PLS_EL0, 3'h5, 1'b0, '{16'hc006, 8'h22, 1'b1}},
    '{PLS_REQ_DATA, PLS_EL3, 3'h0, 1'b1, '{16'h040d, 8'h41, 1'b0}}};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic featurePresent = 1'b0;
  pls_ctrl_s ctrl = '0;
  logic [7:0] validBits = 8'hff;
  logic reqValid = 1'b0;
  pls_req_e reqKind = PLS_REQ_DATA;
  pls_level_e level = PLS_EL3;
  logic secureState = 1'b0;
  pls_level_e ownerLevel = PLS_EL2;
  logic ownerSecure = 1'b1;
  logic sysValid = 1'b0;
  logic sysWrite = 1'b0;
  pls_reg_e sysReg = PLS_REG_APP;
  pls_label_s sysWdata = '0;
  logic [63:0] featureIdReg;
  logic outValid, sysDone, sysFault;
  pls_tag_s outTag;
  pls_label_s sysRdata;
  logic [15:0] sinkCount;
  int nMismatch = 0;
  int comparisons = 0;
  always #25 clk = ~clk;
  pls_label_select u_dut (.clk(clk), .reset(reset), .featurePresent(featurePresent),
    .ctrl(ctrl), .defaultVirtId(16'h0000), .validBits(validBits),
    .physTable(128'hc007_c006_c005_c004_c003_c002_c001_c000), .reqValid(reqValid),
    .reqKind(reqKind), .level(level), .secureState(secureState), .ownerLevel(ownerLevel),
    .ownerSecure(ownerSecure), .sysValid(sysValid), .sysWrite(sysWrite), .sysReg(sysReg),
    .sysWdata(sysWdata), .featureIdReg(featureIdReg), .outValid(outValid), .outTag(outTag),
    .sysDone(sysDone), .sysFault(sysFault), .sysRdata(sysRdata));
  pls_mem_sink u_sink (.clk(clk), .reset(reset), .reqValid(outValid), .tag(outTag),
    .accepted(sinkCount));
  task automatic giveVerdict();
    if (nMismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_tag(input string what, input pls_tag_s exp, input pls_tag_s got);
    comparisons++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_val(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one register access; an idle edge first so sysValid never toggles twice in a step
  task automatic sys(input logic wr, input pls_reg_e r, input pls_level_e l, input pls_label_s d);
    @(posedge clk);
    #1;
    {sysValid, sysWrite, sysReg, level, sysWdata} = {1'b1, wr, r, l, d};
    @(posedge clk);
    #1;
    sysValid = 1'b0;
  endtask
  // data and instruction ids differ in every label so a swapped side shows up
  function automatic pls_label_s lbl(input int r);
    return {8'(r + 1), 8'h0d, 8'(r + 1), 8'h0e, 4'(r + 1), 4'h1, 4'(r + 1), 4'h2};
  endfunction
  // c is {trap lower, application trap, guest trap}
  function automatic logic denied(input int r, input int l, input logic [2:0] c);
    return l < (c[2] || r == 3 ? 3 : (r == 2 || c[1 - r] ? 2 : 1));
  endfunction
  initial begin
    #100000;
    nMismatch++;
    giveVerdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1;
    reset = 1'b0;
    featurePresent = 1'b1;
    sys(0, PLS_REG_APP, PLS_EL3, '0);
    chk_val("reset label", 64'h0, 64'(sysRdata));
    for (int r = 0; r < 4; r++) sys(1, pls_reg_e'(r), PLS_EL3, lbl(r));
    foreach (rw[i]) begin
      {reqValid, reqKind, level, secureState} = {1'b1, rw[i].kind, rw[i].lvl, rw[i].sec};
      {ctrl.guestAppLock, ctrl.level0MapEnable, ctrl.level1MapEnable} = rw[i].ctl;
      @(posedge clk);
      #1;
      chk_tag("tag", rw[i].exp, outTag);
    end
    {reqKind, ownerLevel, ownerSecure} = {PLS_REQ_PROFBUF, PLS_EL1, 1'b0};
    @(posedge clk);
    #1;
    chk_tag("owner", '{16'h020d, 8'h21, 1'b1}, outTag);
    // id 0x010d folds to entry 5, left invalid, so default entry 0 answers
    validBits = 8'h01;
    {reqKind, level, ctrl.guestAppLock, ctrl.level0MapEnable} = {PLS_REQ_DATA, PLS_EL0, 1'b0, 1'b1};
    @(posedge clk);
    #1;
    chk_tag("default entry", '{16'hc000, 8'h11, 1'b0}, outTag);
    validBits = 8'h00;
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    chk_tag("default id", '{PLS_DEFAULT_PARTITION_ID, 8'h11, 1'b0}, outTag);
    @(posedge clk);
    #1;
    chk_val("accepted", 64'hd, 64'(sinkCount));
    for (int c = 0; c < 8; c++) begin
      {ctrl.trapLowerA, ctrl.appRegTrap, ctrl.guestRegTrap} = 3'(c);
      for (int r = 0; r < 4; r++)
        for (int l = 0; l < 4; l++) begin
          sys(0, pls_reg_e'(r), pls_level_e'(l), '0);
          chk_val("fault", 64'(denied(r, l, 3'(c))), 64'(sysFault));
          chk_val("rdata", denied(r, l, 3'(c)) ? 64'h0 : 64'(lbl(r)), 64'(sysRdata));
        end
    end
    ctrl = '0;
    sys(1, PLS_REG_MON, PLS_EL2, '0);
    sys(0, PLS_REG_MON, PLS_EL3, '0);
    chk_val("kept", 64'(lbl(3)), 64'(sysRdata));
    ctrl.hostExtensionBit = 1'b1;
    sys(1, PLS_REG_GUEST, PLS_EL2, lbl(7));
    sys(0, PLS_REG_HYP, PLS_EL2, '0);
    chk_val("redirect", 64'(lbl(7)), 64'(sysRdata));
    sys(0, PLS_REG_HOST_ALIAS, PLS_EL2, '0);
    chk_val("alias", 64'(lbl(1)), 64'(sysRdata));
    chk_val("feature", 64'h0000010000000000, featureIdReg);
    featurePresent = 1'b0;
    @(posedge clk);
    #1;
    chk_val("absent", 64'h0, featureIdReg);
    reset = 1'b1;
    @(posedge clk);
    #1;
    reset = 1'b0;
    sys(0, PLS_REG_HOST_ALIAS, PLS_EL3, '0);
    chk_val("cleared", 64'h0, 64'(sysRdata));
    giveVerdict();
  end
endmodule
`default_nettype wire
